// *** include/smc_cfg.svh ***
// Constants of the serial master/slave core
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_DW 16
`define SMC_DEPTH 3'h4
`define SMC_PTR_ONE 2'h1
`define SMC_CNT_ONE 3'h1
`define SMC_BIT_ONE 4'h1
`define SMC_RELOAD_MIN 17'h00002
`define SMC_RELOAD_WRAP 17'h10000
`define SMC_DIV_ONE 17'h00001
`define SMC_WORD_ZERO 16'h0000
`define SMC_WORD_ONES 16'hffff
`define SMC_SCK_MIN_PERIODS 8
`endif

// *** include/smc_pkg.sv ***
// Types of the serial master/slave core
package smc_pkg;
   typedef struct packed {
      logic enable;
      logic master_select_bit;
      logic sck_idle_polarity;
      logic sck_phase;
      logic select_direction;
      logic select_out_value;
      logic [3:0] char_length;
      logic [15:0] baud_reload;
   } smc_cfg_t;
   typedef struct packed {
      logic abt;
      logic rovr;
      logic col;
   } smc_stat_t;
   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic mosi_out;
      logic mosi_oe;
      logic miso_out;
      logic miso_oe;
      logic ss_n_out;
      logic ss_n_oe;
   } smc_pins_t;
   typedef enum logic [1:0] {
      SMC_IDLE = 2'b00,
      SMC_RUN = 2'b01
   } smc_state_t;
endpackage : smc_pkg

// *** rtl/smc_core.sv ***
// Serial master/slave core with transmit and receive FIFOs
`include "smc_cfg.svh"

// Operation
// - Character length 1 to 16 bits, sent MSB first from bit 15.
// - Each transfer shifts out one line while shifting in the other.
// - Separate transmit and receive FIFOs, four 16-bit entries each.
// - Next transmit word loads into the shifter at transfer start in phase 0, at the first leading edge in phase 1, if present.
// - Completed received character is moved into the receive FIFO unless it is full.
// - Serial clock never faster than a quarter of the system clock.
// - After reset every serial pin is an input.
// - Unselected slave keeps its MISO output released.
// - Disabled unit releases both MISO and MOSI.
// - Master drives SCK from its own baud generator.
// - Slave takes SCK as input, ignored while not selected.
// - A character takes exactly char_length SCK cycles, 16 when char_length is 0.
// - Data changes on one SCK edge and is sampled on the other.
// - Enabled unit with select direction 1 drives select pin with the select value.
// - Select direction 0 makes the select pin an input.
// - Master with select as input flags collision when select goes low.
// - Master when master select bit set, slave when clear.
// - Phase and polarity choose transmit, receive edges and idle level.
// - SCK is system clock over twice the reload, reload at least 2.
module smc_core (
   input wire logic clk_sys,
   input wire logic rst,
   input smc_pkg::smc_cfg_t cfg,
   input smc_pkg::smc_stat_t stat_clear,
   input wire logic [15:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [15:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output smc_pkg::smc_stat_t stat,
   output logic busy,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   input wire logic ss_n_in,
   output smc_pkg::smc_pins_t pins
);
   function automatic logic [1:0] ptr_inc(input logic [1:0] p);
      ptr_inc = p + `SMC_PTR_ONE;
   endfunction : ptr_inc

   function automatic logic [15:0] len_mask(input logic [3:0] len);
      len_mask = (len == 4'h0) ? `SMC_WORD_ONES : ~(`SMC_WORD_ONES << len);
   endfunction : len_mask

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [15:0] tx_mem [0:3];
   logic [15:0] rx_mem [0:3];
   logic [1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
   logic [2:0] tx_cnt_r, rx_cnt_r, tx_cnt_nxt;
   logic tx_ready_r, rx_valid_r;
   logic [15:0] rx_data_r;
   logic [15:0] sh_r, rx_sh_r;
   logic [3:0] bit_r;
   logic pend_r, sck_lvl_r, busy_r;
   logic [16:0] div_r;
   smc_pkg::smc_state_t state_r;
   smc_pkg::smc_stat_t stat_r;
   smc_pkg::smc_pins_t pins_r;
   logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, ss_s1, ss_s2, ss_s3;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire en = cfg.enable;
   wire is_master = cfg.master_select_bit;
   wire cpol = cfg.sck_idle_polarity;
   wire cpha = cfg.sck_phase;
   wire tx_ne = tx_cnt_r != 3'h0;
   wire rx_full = rx_cnt_r == `SMC_DEPTH;
   wire running = state_r == smc_pkg::SMC_RUN;
   wire [16:0] reload_raw = {1'b0, cfg.baud_reload};
   wire [16:0] reload_w = (reload_raw == 17'h0) ? `SMC_RELOAD_WRAP :
                          (reload_raw < `SMC_RELOAD_MIN) ? `SMC_RELOAD_MIN : reload_raw;
   wire tick = running && (div_r == reload_w - `SMC_DIV_ONE);
   wire lead_m = tick && !sck_lvl_r;
   wire trail_m = tick && sck_lvl_r;
   wire sel = en && !is_master && !ss_s2;
   wire lead_s = sel && (sck_s2 != cpol) && (sck_s3 == cpol);
   wire trail_s = sel && (sck_s2 == cpol) && (sck_s3 != cpol);
   wire lead_ev = is_master ? lead_m : lead_s;
   wire trail_ev = is_master ? trail_m : trail_s;
   wire sample_ev = cpha ? trail_ev : lead_ev;
   wire shift_ev = cpha ? lead_ev : trail_ev;
   wire din = is_master ? miso_in : mosi_s2;
   wire [3:0] last_bit = cfg.char_length - `SMC_BIT_ONE;
   wire done_w = sample_ev && (bit_r == last_bit);
   wire [15:0] rx_word = {rx_sh_r[14:0], din} & len_mask(cfg.char_length);
   wire start_m = en && is_master && !running && tx_ne;
   wire sel_start = en && !is_master && ss_s3 && !ss_s2;
   wire sel_end = en && !is_master && !ss_s3 && ss_s2;
   wire stop_m = trail_m && !tx_ne && (cpha ? done_w : pend_r);
   // phase 0 load at start of each transfer
   wire load_now = (start_m || sel_start) && !cpha && tx_ne;
   wire load_shift = shift_ev && pend_r && tx_ne;
   wire tx_pop = load_now || load_shift;
   wire tx_push = tx_valid && tx_ready_r;
   wire rx_push = done_w && !rx_full;
   wire rx_pop = (rx_cnt_r != 3'h0) && (!rx_valid_r || rx_ready);
   wire col_set = en && is_master && !cfg.select_direction && !ss_s2;
   wire abt_set = sel_end && (bit_r != 4'h0);
   smc_pkg::smc_stat_t stat_set;
   assign stat_set = '{abt: abt_set, rovr: done_w && rx_full, col: col_set};
   assign tx_cnt_nxt = tx_cnt_r + {2'b00, tx_push} - {2'b00, tx_pop};

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   // two-flop sync before edge detect
   // sync delay bounds the slave SCK rate
   always_ff @(posedge clk_sys) begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      ss_s1 <= ss_n_in;
      ss_s2 <= ss_s1;
      ss_s3 <= ss_s2;
   end

   // ----------------------------------------
   // FIFOs
   // ----------------------------------------
   // two 4x16 FIFOs
   always_ff @(posedge clk_sys) begin
      if (tx_push) begin
         tx_mem[tx_wp_r] <= tx_data;
      end
      if (rx_push) begin
         rx_mem[rx_wp_r] <= rx_word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_wp_r <= 2'h0;
         tx_rp_r <= 2'h0;
         tx_cnt_r <= 3'h0;
         tx_ready_r <= 1'b0;
      end else begin
         if (tx_push) begin
            tx_wp_r <= ptr_inc(tx_wp_r);
         end
         if (tx_pop) begin
            tx_rp_r <= ptr_inc(tx_rp_r);
         end
         tx_cnt_r <= tx_cnt_nxt;
         tx_ready_r <= tx_cnt_nxt != `SMC_DEPTH;
      end
   end

   // Output stage keeps a word while the receiver stalls
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_wp_r <= 2'h0;
         rx_rp_r <= 2'h0;
         rx_cnt_r <= 3'h0;
         rx_valid_r <= 1'b0;
         rx_data_r <= `SMC_WORD_ZERO;
      end else begin
         if (rx_push) begin
            rx_wp_r <= ptr_inc(rx_wp_r);
         end
         if (rx_pop) begin
            rx_rp_r <= ptr_inc(rx_rp_r);
            rx_data_r <= rx_mem[rx_rp_r];
            rx_valid_r <= 1'b1;
         end else if (rx_ready) begin
            rx_valid_r <= 1'b0;
         end
         rx_cnt_r <= rx_cnt_r + {2'b00, rx_push} - {2'b00, rx_pop};
      end
   end

   // ----------------------------------------
   // Baud generator and master sequencer
   // ----------------------------------------
   // master clock from divider
   always_ff @(posedge clk_sys) begin
      if (rst || !en || !is_master) begin
         state_r <= smc_pkg::SMC_IDLE;
         div_r <= 17'h0;
         sck_lvl_r <= 1'b0;
      end else begin
         case (state_r)
            smc_pkg::SMC_IDLE: begin
               div_r <= 17'h0;
               sck_lvl_r <= 1'b0;
               if (start_m) begin
                  state_r <= smc_pkg::SMC_RUN;
               end
            end
            smc_pkg::SMC_RUN: begin
               div_r <= tick ? 17'h0 : div_r + `SMC_DIV_ONE;
               if (tick) begin
                  sck_lvl_r <= !sck_lvl_r;
               end
               if (stop_m) begin
                  state_r <= smc_pkg::SMC_IDLE;
               end
            end
            default: state_r <= smc_pkg::SMC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   // MSB out of bit 15
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sh_r <= `SMC_WORD_ZERO;
         rx_sh_r <= `SMC_WORD_ZERO;
         bit_r <= 4'h0;
         pend_r <= 1'b0;
      end else if (!en || sel_end) begin
         bit_r <= 4'h0;
         pend_r <= 1'b0;
      end else begin
         if (load_now) begin
            sh_r <= tx_mem[tx_rp_r];
         end else if (shift_ev) begin
            sh_r <= pend_r ? (tx_ne ? tx_mem[tx_rp_r] : sh_r) : {sh_r[14:0], 1'b0};
         end
         if (sample_ev) begin
            rx_sh_r <= {rx_sh_r[14:0], din};
            bit_r <= done_w ? 4'h0 : bit_r + `SMC_BIT_ONE;
         end
         // Phase 1 waits for its first leading edge; phase 0 drops a flag left by phase 1
         if (start_m || sel_start) begin
            pend_r <= cpha;
         end else if (done_w) begin
            pend_r <= 1'b1;
         end else if (shift_ev) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stat_r <= '0;
         busy_r <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~stat_clear) | stat_set;
         busy_r <= running || (bit_r != 4'h0);
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // all enables low from reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pins_r <= '0;
      end else begin
         pins_r.sck_out <= cpol ^ sck_lvl_r;
         pins_r.sck_oe <= en && is_master;
         pins_r.mosi_out <= sh_r[15];
         pins_r.mosi_oe <= en && is_master;
         pins_r.miso_out <= sh_r[15];
         pins_r.miso_oe <= sel;
         pins_r.ss_n_out <= cfg.select_out_value;
         pins_r.ss_n_oe <= en && cfg.select_direction;
      end
   end

   assign tx_ready = tx_ready_r;
   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;
   assign stat = stat_r;
   assign busy = busy_r;
   assign pins = pins_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_unselected;
      (en && !is_master && ss_s2) [*2];
   endsequence

   property p_release_off;
      !en |=> !pins_r.mosi_oe && !pins_r.miso_oe && !pins_r.sck_oe;
   endproperty
   a_release_off: assert property (p_release_off) else $error("pins driven while off");

   property p_miso_unsel;
      s_unselected |=> !pins_r.miso_oe;
   endproperty
   a_miso_unsel: assert property (p_miso_unsel) else $error("miso driven unselected");

   property p_sck_rate;
      pins_r.sck_oe && $stable(cpol) && $changed(pins_r.sck_out) |=> $stable(pins_r.sck_out);
   endproperty
   a_sck_rate: assert property (p_sck_rate) else $error("sck too fast");

   property p_ss_out;
      en && cfg.select_direction |=> pins_r.ss_n_oe && pins_r.ss_n_out == $past(cfg.select_out_value);
   endproperty
   a_ss_out: assert property (p_ss_out) else $error("select not driven");

   property p_ss_in;
      !cfg.select_direction |=> !pins_r.ss_n_oe;
   endproperty
   a_ss_in: assert property (p_ss_in) else $error("select driven as input");

   property p_collision;
      col_set |=> stat_r.col;
   endproperty
   a_collision: assert property (p_collision) else $error("collision not flagged");

   property p_rx_push;
      done_w && !rx_full && !rx_pop |=> rx_cnt_r == $past(rx_cnt_r) + `SMC_CNT_ONE;
   endproperty
   a_rx_push: assert property (p_rx_push) else $error("received word lost");

   property p_ignore_sck;
      en && !is_master && ss_s2 && ss_s3 |=> $stable(bit_r) && $stable(rx_sh_r);
   endproperty
   a_ignore_sck: assert property (p_ignore_sck) else $error("sck taken unselected");

   property p_load;
      start_m && !cpha |=> sh_r == $past(tx_mem[tx_rp_r]);
   endproperty
   a_load: assert property (p_load) else $error("tx word not loaded");
endmodule : smc_core

// *** tb/smc_peer.sv ***
// Behavioural far-end serial device that echoes the previous character
module smc_peer (
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [4:0] nbits,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sr = 16'h3c5a;
   logic [15:0] rx = 16'h0000;
   logic bit_r = 1'b0;
   int cnt = 0;
   // released line
   // No pull on this line, so a stale bit must never look valid
   assign miso = ss_n ? ~bit_r : bit_r;
   always @(negedge ss_n) begin
      cnt = 0;
      if (!cpha) begin
         bit_r = sr[nbits - 5'h1];
      end
   end
   always @(sck) begin
      if (!ss_n) begin
         if ((sck != cpol) ^ cpha) begin
            rx = {rx[14:0], mosi};
            cnt++;
            if (cnt == nbits) begin
               sr = rx;
               cnt = 0;
            end
         end else begin
            bit_r = sr[nbits - 5'h1 - cnt];
         end
      end
   end
endmodule : smc_peer

// *** tb/tb.sv ***
// Self-checking bench of the serial core as master against an echoing peer, then as slave
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   smc_pkg::smc_cfg_t cfg = '0;
   smc_pkg::smc_stat_t stat_clear = '0;
   logic [15:0] tx_data = 16'h0000;
   logic tx_valid = 1'b0;
   logic tx_ready;
   logic [15:0] rx_data;
   logic rx_valid;
   logic rx_ready = 1'b0;
   smc_pkg::smc_stat_t stat;
   logic busy;
   smc_pkg::smc_pins_t pins;
   logic ss_ext = 1'b1;
   logic sck_ext = 1'b1;
   logic mosi_ext = 1'b0;
   logic [15:0] s_word [0:1];
   logic [15:0] s_got;
   logic [15:0] s_mo;
   logic tog = 1'b0;
   logic sck_q = 1'b0;
   logic miso_w;
   logic [15:0] hist = 16'h3c5a;
   logic [15:0] exp_q[$];
   int seed = 74;
   int n_fail = 0;
   int check_count = 0;
   int gap = 0;
   wire logic [4:0] nbits = (cfg.char_length == 4'h0) ? 5'h10 : {1'b0, cfg.char_length};
   // Clock and select idle high; an undriven data line toggles every cycle while the external select is high
   wire logic sck_w = pins.sck_oe ? pins.sck_out : sck_ext;
   wire logic ss_w = pins.ss_n_oe ? pins.ss_n_out : ss_ext;
   wire logic mosi_w = pins.mosi_oe ? pins.mosi_out : (ss_ext ? tog : mosi_ext);

   smc_core dut_u (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .stat_clear(stat_clear),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .stat(stat), .busy(busy), .sck_in(sck_w),
      .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_w), .pins(pins));
   smc_peer peer_u (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .cpol(cfg.sck_idle_polarity),
      .cpha(cfg.sck_phase), .nbits(nbits), .miso(miso_w));

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task test_done;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // Valid stays high after the accepting edge so back-to-back words need no gap
   task push_word(input logic [15:0] d);
      tx_data = d;
      tx_valid = 1'b1;
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
      #1;
   endtask : push_word

   // Expected word is the peer's echo of the bits it last shifted in
   task send_burst(input int n);
      logic [15:0] w;
      for (int i = 0; i < n; i++) begin
         w = 16'($random(seed));
         exp_q.push_back(16'(hist & ((32'h1 << nbits) - 32'h1)));
         hist = 16'(({16'h0000, hist} << nbits) | (w >> (5'h10 - nbits)));
         push_word(w);
      end
      tx_valid = 1'b0;
   endtask : send_burst

   task slave_bits(input int n, input logic [15:0] m, output logic [15:0] got);
      got = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_ext = m[i];
         tick(4);
         sck_ext = 1'b1;
         got[i] = pins.miso_out;
         tick(4);
         sck_ext = 1'b0;
      end
   endtask : slave_bits

   // ---------------------------------------------
   // Clock, receiver stalls and monitors
   // ---------------------------------------------
   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      tog <= ~tog;
      #1;
      rx_ready = (($random(seed) & 3) != 0);
   end

   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("rx_extra", 16'h0000, 16'hffff);
         end else begin
            chk("rx_data", exp_q.pop_front(), rx_data);
         end
      end
   end

   always @(posedge clk_sys) begin
      gap++;
      if (pins.sck_out !== sck_q) begin
         if (busy === 1'b1) begin
            chk("sck_half", 16'h0001, 16'(gap >= cfg.baud_reload));
         end
         gap = 0;
      end
      sck_q = pins.sck_out;
   end

   initial begin
      #200000;
      chk("watchdog", 16'h0000, 16'h0001);
      test_done();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      tick(2);
      chk("oe_rst", 16'h0000, 16'({pins.sck_oe, pins.mosi_oe, pins.miso_oe, pins.ss_n_oe}));
      rst = 1'b0;
      cfg.enable = 1'b1;
      cfg.master_select_bit = 1'b1;
      cfg.select_direction = 1'b1;
      for (int b = 0; b < 8; b++) begin
         cfg.select_out_value = 1'b1;
         // Select rises before the mode changes, so the peer sees no edge while selected
         tick(2);
         cfg.sck_phase = b[0];
         cfg.sck_idle_polarity = b[1];
         cfg.char_length = 4'($random(seed));
         cfg.baud_reload = 16'(2 + ($random(seed) & 3));
         tick(4);
         chk("ss_pin", 16'h0003, 16'({pins.ss_n_oe, pins.ss_n_out}));
         chk("sck_idle", 16'(cfg.sck_idle_polarity), 16'(pins.sck_out));
         cfg.select_out_value = 1'b0;
         tick(2);
         send_burst(5);
         for (int i = 0; i < 4000 && (exp_q.size() != 0 || busy !== 1'b0); i++) begin
            @(posedge clk_sys);
         end
         #1;
         chk("rx_left", 16'h0000, 16'(exp_q.size()));
         chk("rovr_busy", 16'h0000, 16'({stat.rovr, busy}));
      end
      cfg.select_direction = 1'b0;
      ss_ext = 1'b0;
      tick(6);
      chk("col_set", 16'h0001, 16'({pins.ss_n_oe, stat.col}));
      ss_ext = 1'b1;
      tick(4);
      stat_clear.col = 1'b1;
      tick(1);
      stat_clear.col = 1'b0;
      tick(1);
      chk("col_clr", 16'h0000, 16'(stat.col));
      cfg.master_select_bit = 1'b0;
      tick(6);
      chk("slave_oe", 16'h0000, 16'({pins.sck_oe, pins.miso_oe}));
      cfg.sck_idle_polarity = 1'b0;
      cfg.sck_phase = 1'b0;
      cfg.char_length = 4'h8;
      sck_ext = 1'b0;
      for (int k = 0; k < 2; k++) begin
         s_word[k] = 16'($random(seed));
         push_word(s_word[k]);
      end
      tx_valid = 1'b0;
      ss_ext = 1'b0;
      tick(4);
      chk("miso_oe_sel", 16'h0001, 16'(pins.miso_oe));
      for (int k = 0; k < 2; k++) begin
         s_mo = 16'($random(seed) & 32'hff);
         exp_q.push_back(s_mo);
         slave_bits(8, s_mo, s_got);
         chk("miso_char", {8'h00, s_word[k][15:8]}, s_got);
      end
      ss_ext = 1'b1;
      tick(8);
      chk("abt_full", 16'h0000, 16'({stat.abt, busy}));
      ss_ext = 1'b0;
      tick(4);
      slave_bits(3, 16'h0005, s_got);
      ss_ext = 1'b1;
      tick(6);
      chk("abt_cut", 16'h0001, 16'(stat.abt));
      chk("rx_left_s", 16'h0000, 16'(exp_q.size()));
      cfg.enable = 1'b0;
      tick(4);
      chk("off_oe", 16'h0000, 16'({pins.mosi_oe, pins.miso_oe}));
      test_done();
   end
endmodule : tb
